/* File: rtl/tdm_timer.v */
// Operation
// - When enabled, counter idles until first qualifying edge; that edge only starts counting.
// - Edge qualified by polarity bit; both-edges bit overrides it, both edges qualify.
// - Later qualifying edges copy the 16-bit count; rising edges go to rising pair.
// - Falling qualifying edges store the count into the falling capture pair.
// - Each capture requests the interrupt; counter keeps running, no reset, no pause.
// - Each capture sets the capture event flag for the pair written.
// - Count reaching reload value requests interrupt, loads 0001h and continues.
// - Each reload sets the reload event flag in status.
// - Demodulation runs when 4-bit mode field (top bit in ctl0) equals 1100.
// - Default both events interrupt; config 10 capture only; 11 reload only.
// - 3-bit prescale divides timer clock; 000 divides by one.
// - Clock source bit 1 selects the 32kHz peripheral clock as timer clock.
// - Cascade select 0 takes timer input from the pin, else from other timer.
// - Dual-output delay field and capture indicator bit have no effect here.
// - Enable 0 stops the timer; software configures while disabled, enables last.
// - Filter enable routes input through filter; control 100 gives 8-bit counter.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "tdm_regs.vh"

module tdm_timer #(
    parameter CNT_W = 16
) (
    // Clock and reset
    input  wire             mclk,
    input  wire             rst_n,
    // Register port
    input  wire [3:0]       reg_addr,
    input  wire [7:0]       reg_wdata,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [7:0]       reg_rdata,
    // Timer clock ticks and input sources
    input  wire             sys_tick,
    input  wire             per32k_tick,
    input  wire             pin_in,
    input  wire             cascade_in,
    // Interrupt request
    output reg              timer_irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    reg [7:0]        ctl0_q;
    reg [7:0]        ctl1_q;
    reg [7:0]        ctl2_q;
    reg [7:0]        nfc_q;
    reg [CNT_W-1:0]  cnt_q;
    reg [CNT_W-1:0]  rld_q;
    reg [CNT_W-1:0]  rise_q;
    reg [CNT_W-1:0]  fall_q;
    reg [2:0]        stat_q;
    reg [6:0]        prescale_field_q;
    reg              running_q;
    reg              in_q;
    reg [10:0]       filt_q;
    reg              filt_out_q;

    wire             enable     = ctl1_q[`TDM_C1_ENABLE];
    // Mode field is split: top bit in control 0, lower three bits in control 1
    wire [3:0]       mode       = {ctl0_q[`TDM_C0_MODE_TOP], ctl1_q[`TDM_C1_MODE_HI:`TDM_C1_MODE_LO]};
    wire             demod      = enable && (mode == `TDM_MODE_DEMOD);
    wire [1:0]       irq_cfg    = ctl0_q[`TDM_C0_IRQCFG_HI:`TDM_C0_IRQCFG_LO];
    wire [2:0]       prescale_field_sel   = ctl1_q[`TDM_C1_PRESCALE_FIELD_HI:`TDM_C1_PRESCALE_FIELD_LO];
    wire             polarity   = ctl1_q[`TDM_C1_POLARITY];
    wire             both_edges = ctl2_q[`TDM_C2_BOTH_EDGES];
    wire             filt_en    = nfc_q[`TDM_NF_ENABLE];
    wire [2:0]       filt_ctl   = nfc_q[`TDM_NF_CTL_HI:`TDM_NF_CTL_LO];

    ////////////////////////////////////////////////////////////////////////////
    // Timer clock and prescaler
    // Delay field and capture indicator are deliberately not decoded
    // Tick inputs are one-cycle enables; the block never switches clocks
    // Divide ratio is two to the power of the prescale field, up to 128
    wire tclk = ctl2_q[`TDM_C2_CLK_SRC] ? per32k_tick : sys_tick;
    wire [6:0] prescale_field_max  = (7'h01 << prescale_field_sel) - 7'h01;
    wire       prescale_field_tick = tclk && (prescale_field_q == prescale_field_max);

    // Prescale count, held at zero until the start edge so the first tick is a full period
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_field_q <= 7'h00;
        end else if (!demod || !running_q) begin
            prescale_field_q <= 7'h00;
        end else if (tclk) begin
            prescale_field_q <= prescale_field_tick ? 7'h00 : prescale_field_q + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input select and noise filter
    // Cascade input is taken as already synchronous, like the pin
    wire raw_in = ctl0_q[`TDM_C0_CASCADE] ? cascade_in : pin_in;
    // Filter width is 4 + control bits; 100 gives an 8-bit counter
    wire [3:0]  filt_w   = `TDM_NF_MIN_W + {1'b0, filt_ctl};
    wire [10:0] filt_top = (11'h001 << filt_w) - 11'h001;

    // Saturating up/down counter with hysteresis, stepped on timer clock
    // Output flips only at the saturated ends, so short glitches never reach it
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            filt_q     <= 11'h000;
            filt_out_q <= 1'b0;
        end else if (tclk) begin
            if (raw_in && filt_q < filt_top) begin
                filt_q <= filt_q + 11'h001;
                if (filt_q == filt_top - 11'h001) begin
                    filt_out_q <= 1'b1;
                end
            end else if (!raw_in && filt_q != 11'h000) begin
                filt_q <= filt_q - 11'h001;
                if (filt_q == 11'h001) begin
                    filt_out_q <= 1'b0;
                end
            end else if (filt_q > filt_top) begin
                filt_q <= filt_top;
            end
        end
    end

    wire tin = filt_en ? filt_out_q : raw_in;

    // Previous input level for edge detection
    // Reset level matches the idle low input, so no false edge follows reset
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            in_q <= 1'b0;
        end else begin
            in_q <= tin;
        end
    end

    wire rise_edge = tin && !in_q;
    wire fall_edge = !tin && in_q;
    // Both-edges bit overrides polarity
    wire qual_rise = rise_edge && (both_edges || polarity);
    wire qual_fall = fall_edge && (both_edges || !polarity);
    wire qual_edge = demod && (qual_rise || qual_fall);

    ////////////////////////////////////////////////////////////////////////////
    // Event decode
    // The first edge only arms the counter; running_q gates every capture
    wire capt_rise  = qual_edge && running_q && rise_edge;
    wire capt_fall  = qual_edge && running_q && fall_edge;
    wire reload_ev  = demod && running_q && prescale_field_tick && (cnt_q == rld_q);

    wire wr_ctl0 = reg_wr && (reg_addr == `TDM_ADDR_CTL0);
    wire wr_ctl1 = reg_wr && (reg_addr == `TDM_ADDR_CTL1);
    wire wr_ctl2 = reg_wr && (reg_addr == `TDM_ADDR_CTL2);
    wire wr_nfc  = reg_wr && (reg_addr == `TDM_ADDR_NFC);
    wire wr_stat = reg_wr && (reg_addr == `TDM_ADDR_STAT);

    // Byte lanes of the 16-bit registers
    wire wr_cnt_hi  = reg_wr && (reg_addr == `TDM_ADDR_CNT_HI);
    wire wr_cnt_lo  = reg_wr && (reg_addr == `TDM_ADDR_CNT_LO);
    wire wr_rld_hi  = reg_wr && (reg_addr == `TDM_ADDR_RLD_HI);
    wire wr_rld_lo  = reg_wr && (reg_addr == `TDM_ADDR_RLD_LO);
    wire wr_rise_hi = reg_wr && (reg_addr == `TDM_ADDR_RISE_HI);
    wire wr_rise_lo = reg_wr && (reg_addr == `TDM_ADDR_RISE_LO);
    wire wr_fall_hi = reg_wr && (reg_addr == `TDM_ADDR_FALL_HI);
    wire wr_fall_lo = reg_wr && (reg_addr == `TDM_ADDR_FALL_LO);

    ////////////////////////////////////////////////////////////////////////////
    // Control registers
    // Written whole; software clears enable before touching the other fields
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctl0_q <= `TDM_RST_CTL;
            ctl1_q <= `TDM_RST_CTL;
            ctl2_q <= `TDM_RST_CTL;
            nfc_q  <= `TDM_RST_CTL;
        end else begin
            if (wr_ctl0) begin
                ctl0_q <= reg_wdata;
            end
            if (wr_ctl1) begin
                ctl1_q <= reg_wdata;
            end
            if (wr_ctl2) begin
                ctl2_q <= reg_wdata;
            end
            if (wr_nfc) begin
                nfc_q <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Start arm: idle until first qualifying edge
    // Cleared whenever the mode drops, so a re-enable waits for a fresh start edge
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            running_q <= 1'b0;
        end else if (!demod) begin
            running_q <= 1'b0;
        end else if (qual_edge) begin
            running_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reload value, written a byte at a time
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rld_q <= `TDM_RST_RLD;
        end else begin
            if (wr_rld_hi) begin
                rld_q[15:8] <= reg_wdata;
            end
            if (wr_rld_lo) begin
                rld_q[7:0] <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter: a software load beats the reload, the reload beats the increment
    // A terminal count below the count already reached is missed until the count wraps
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `TDM_RST_CNT;
        end else if (wr_cnt_hi) begin
            cnt_q[15:8] <= reg_wdata;
        end else if (wr_cnt_lo) begin
            cnt_q[7:0] <= reg_wdata;
        end else if (reload_ev) begin
            cnt_q <= `TDM_RELOAD_START;
        end else if (demod && running_q && prescale_field_tick) begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rising capture pair; a capture landing on a software write wins
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rise_q <= `TDM_RST_CAPT;
        end else if (capt_rise) begin
            rise_q <= cnt_q;
        end else begin
            if (wr_rise_hi) begin
                rise_q[15:8] <= reg_wdata;
            end
            if (wr_rise_lo) begin
                rise_q[7:0] <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Falling capture pair, same priority as the rising pair
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fall_q <= `TDM_RST_CAPT;
        end else if (capt_fall) begin
            fall_q <= cnt_q;
        end else begin
            if (wr_fall_hi) begin
                fall_q[15:8] <= reg_wdata;
            end
            if (wr_fall_lo) begin
                fall_q[7:0] <= reg_wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sticky event flags: write 1 clears, a new event wins
    // Set beats clear, so an event landing on the clearing write is never lost
    wire [2:0] ev_vec  = {reload_ev, capt_fall, capt_rise};
    wire [2:0] clr_vec = wr_stat ? reg_wdata[2:0] : 3'h0;

    // One flag per event source
    genvar fi;
    generate
        for (fi = 0; fi < 3; fi = fi + 1) begin : g_flag
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    stat_q[fi] <= 1'b0;
                end else if (ev_vec[fi]) begin
                    stat_q[fi] <= 1'b1;
                end else if (clr_vec[fi]) begin
                    stat_q[fi] <= 1'b0;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt request pulse
    // Registered, so the pulse follows the event edge by one cycle
    // Config 10 keeps captures only, 11 reloads only, anything else both
    wire capt_any = capt_rise || capt_fall;
    wire capt_ok  = (irq_cfg != `TDM_IRQ_RLD_ONLY);
    wire rld_ok   = (irq_cfg != `TDM_IRQ_CAPT_ONLY);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= (capt_any && capt_ok) || (reload_ev && rld_ok);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, valid the cycle after the strobe
    // Zero outside the read slot, so a stale value is never taken as fresh
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `TDM_ADDR_CTL0:    reg_rdata <= ctl0_q;
                `TDM_ADDR_CTL1:    reg_rdata <= ctl1_q;
                `TDM_ADDR_CTL2:    reg_rdata <= ctl2_q;
                `TDM_ADDR_CNT_HI:  reg_rdata <= cnt_q[15:8];
                `TDM_ADDR_CNT_LO:  reg_rdata <= cnt_q[7:0];
                `TDM_ADDR_RLD_HI:  reg_rdata <= rld_q[15:8];
                `TDM_ADDR_RLD_LO:  reg_rdata <= rld_q[7:0];
                `TDM_ADDR_RISE_HI: reg_rdata <= rise_q[15:8];
                `TDM_ADDR_RISE_LO: reg_rdata <= rise_q[7:0];
                `TDM_ADDR_FALL_HI: reg_rdata <= fall_q[15:8];
                `TDM_ADDR_FALL_LO: reg_rdata <= fall_q[7:0];
                `TDM_ADDR_STAT:    reg_rdata <= {5'h00, stat_q};
                `TDM_ADDR_NFC:     reg_rdata <= nfc_q;
                default:           reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

/* File: rtl/tdm_regs.vh */
`ifndef TDM_REGS_VH
`define TDM_REGS_VH

// Register addresses (byte-wide registers, 4-bit address)
`define TDM_ADDR_CTL0      4'h0
`define TDM_ADDR_CTL1      4'h1
`define TDM_ADDR_CTL2      4'h2
`define TDM_ADDR_CNT_HI    4'h3
`define TDM_ADDR_CNT_LO    4'h4
`define TDM_ADDR_RLD_HI    4'h5
`define TDM_ADDR_RLD_LO    4'h6
`define TDM_ADDR_RISE_HI   4'h7
`define TDM_ADDR_RISE_LO   4'h8
`define TDM_ADDR_FALL_HI   4'h9
`define TDM_ADDR_FALL_LO   4'ha
`define TDM_ADDR_STAT      4'hb
`define TDM_ADDR_NFC       4'hc

// control_reg_0 fields
`define TDM_C0_MODE_TOP    7
`define TDM_C0_IRQCFG_HI   6
`define TDM_C0_IRQCFG_LO   5
`define TDM_C0_DUAL_HI     4
`define TDM_C0_DUAL_LO     2
`define TDM_C0_INPUT_CAPTURE_INDICATOR_IND  1
`define TDM_C0_CASCADE     0
// control_reg_1 fields
`define TDM_C1_ENABLE      7
`define TDM_C1_POLARITY    6
`define TDM_C1_PRESCALE_FIELD_HI     5
`define TDM_C1_PRESCALE_FIELD_LO     3
`define TDM_C1_MODE_HI     2
`define TDM_C1_MODE_LO     0
// control_reg_2 fields
`define TDM_C2_BOTH_EDGES  4
`define TDM_C2_CLK_SRC     0
// Status fields
`define TDM_ST_RISE_EF     0
`define TDM_ST_FALL_EF     1
`define TDM_ST_RELOAD_EF   2
// Noise filter control fields
`define TDM_NF_ENABLE      7
`define TDM_NF_CTL_HI      6
`define TDM_NF_CTL_LO      4
`define TDM_NF_MIN_W       4'h4

// Encodings and reset values
`define TDM_MODE_DEMOD     4'hc
`define TDM_IRQ_CAPT_ONLY  2'h2
`define TDM_IRQ_RLD_ONLY   2'h3
`define TDM_RELOAD_START   16'h0001
`define TDM_RST_CTL        8'h00
`define TDM_RST_CNT        16'h0001
`define TDM_RST_RLD        16'hffff
`define TDM_RST_CAPT       16'h0000

`endif

/* File: verification/tdm_sig_src.sv */
`timescale 1ns/1ps
module tdm_sig_src (
    // Clock and requested pin level
    input  wire  mclk,
    input  wire  lvl,
    // Lines into the timer
    output logic pin_in,
    output logic cascade_in,
    output logic per32k_tick
);
    logic [2:0] div_q;
    ////////////////////////////////////////////////////////////////
    // Quiet start so the timer never sees unknowns
    initial begin
        pin_in      = 1'b0;
        cascade_in  = 1'b0;
        per32k_tick = 1'b0;
        div_q       = 3'h0;
    end
    // Pin follows request; cascade source chatters every cycle
    always @(posedge mclk) begin
        pin_in      <= lvl;
        cascade_in  <= ~cascade_in;
        div_q       <= div_q + 3'h1;
        per32k_tick <= (div_q == 3'h7);
    end
endmodule

/* File: verification/tdm_timer_chk.sv */
`timescale 1ns/1ps
module tdm_timer_chk (
    // Clock and reset
    input wire       mclk,
    input wire       rst_n,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // Timer side
    input wire       sys_tick,
    input wire       per32k_tick,
    input wire       pin_in,
    input wire       cascade_in,
    input wire       timer_irq
);
    logic [7:0] shd_q [16];
    logic [3:0] rda_q, since_q;
    logic [7:0] lo_last_q;
    logic       rdv_q, pin_prev_q, lo_ok_q;
    wire        off = !(shd_q[1][7] && shd_q[0][7] && shd_q[1][2:0] == 3'h4);
    wire [7:0]  m_w = (rda_q == 4'h2) ? 8'h11 : (rda_q == 4'hc) ? 8'hf0 : 8'hff;
    wire        capt_only = shd_q[0][6:5] == 2'h2 && !shd_q[12][7];
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // Shadow registers, read tracking, pin quiet time, frozen count
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++)
                shd_q[i] <= (i == 5 || i == 6) ? 8'hff : 8'h00;
            rdv_q      <= 1'b0;
            rda_q      <= 4'h0;
            pin_prev_q <= 1'b0;
            since_q    <= 4'hf;
            lo_last_q  <= 8'h00;
            lo_ok_q    <= 1'b0;
        end else begin
            if (reg_wr)
                shd_q[reg_addr] <= reg_wdata;
            rdv_q      <= reg_rd;
            rda_q      <= reg_addr;
            pin_prev_q <= pin_in;
            since_q    <= (pin_in != pin_prev_q) ? 4'h0 : since_q + {3'h0, since_q != 4'hf};
            if (rdv_q && rda_q == 4'h4) begin
                lo_last_q <= reg_rdata;
                lo_ok_q   <= off;
            end else if (!off || (reg_wr && (reg_addr == 4'h3 || reg_addr == 4'h4)))
                lo_ok_q <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Bus steps
    sequence s_rd_unmapped;
        reg_rd && reg_addr > 4'hc;
    endsequence
    sequence s_stat_clear;
        off && reg_wr && reg_addr == 4'hb && reg_wdata == 8'h07 ##2 reg_rd && reg_addr == 4'hb;
    endsequence
    // Checks
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    chk_unmapped_zero: assert property (s_rd_unmapped |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_cfg_readback: assert property (rdv_q && rda_q inside {0, 1, 2, 5, 6, 12} |->
        (reg_rdata & m_w) == (shd_q[rda_q] & m_w)) else $error("config readback wrong");
    chk_off_no_irq: assert property (off && $past(off) && $past(off, 2) |-> !timer_irq)
        else $error("interrupt while stopped");
    chk_capt_only_src: assert property (timer_irq && capt_only |-> since_q <= 4'h4)
        else $error("interrupt without capture");
    chk_count_frozen: assert property (rdv_q && rda_q == 4'h4 && lo_ok_q |-> reg_rdata == lo_last_q)
        else $error("count moved while stopped");
    chk_quiet_pin: assert property ((capt_only && since_q == 4'hf) [*3] |-> !timer_irq)
        else $error("interrupt on quiet input");
    chk_stat_clear: assert property (s_stat_clear |=> reg_rdata == 8'h00)
        else $error("status flags not cleared");
endmodule

bind tdm_timer tdm_timer_chk u_chk (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_tick(sys_tick),
    .per32k_tick(per32k_tick), .pin_in(pin_in), .cascade_in(cascade_in), .timer_irq(timer_irq)
);

/* File: verification/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
    logic        mclk, rst_n, reg_wr, reg_rd, lvl, pin_in, cascade_in, per32k_tick, timer_irq;
    logic [3:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, b;
    logic [15:0] r, f, s, t;
    int          bad_count, checked, irq_cnt;
    logic [7:0]  rst_tab [14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hff, 8'hff,
                                  8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0]  tc0 [4] = '{8'h80, 8'h80, 8'h80, 8'hc0};
    logic [7:0]  tc1 [4] = '{8'h04, 8'h14, 8'h04, 8'h04};
    logic [7:0]  tc2 [4] = '{8'h10, 8'h10, 8'h11, 8'h10};
    logic [15:0] trl [4] = '{16'hffff, 16'hffff, 16'hffff, 16'h0010};
    logic [15:0] tdf [4] = '{16'h0032, 16'h0010, 16'h0008, 16'h0000};
    logic [15:0] tst [4] = '{16'h0003, 16'h0003, 16'h0003, 16'h0007};
    int          tgap [4] = '{50, 64, 64, 32};

    tdm_timer dut (
        .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sys_tick(1'b1), .per32k_tick(per32k_tick),
        .pin_in(pin_in), .cascade_in(cascade_in), .timer_irq(timer_irq)
    );
    tdm_sig_src u_src (.mclk(mclk), .lvl(lvl), .pin_in(pin_in), .cascade_in(cascade_in), .per32k_tick(per32k_tick));
    ////////////////////////////////////////////////////////////////
    // Clock and interrupt pulse count
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk)
        if (timer_irq === 1'b1)
            irq_cnt <= irq_cnt + 1;
    ////////////////////////////////////////////////////////////////
    // Register port cycles
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic rd16(input logic [3:0] a, output logic [15:0] v);
        rd(a, v[15:8]);
        rd(a + 4'h1, v[7:0]);
    endtask
    task automatic grab;
        rd16(4'h7, r);
        rd16(4'h9, f);
        rd(4'hb, b);
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Stop, configure, clear captures and flags, start last
    task automatic setup(input logic [7:0] c0, c1, c2, nf, input logic [15:0] rld);
        wr(4'h1, c1 & 8'h7f);
        wr(4'h0, c0);
        wr(4'h2, c2);
        wr(4'h3, 8'h00);
        wr(4'h4, 8'h01);
        wr(4'h5, rld[15:8]);
        wr(4'h6, rld[7:0]);
        for (int i = 7; i < 11; i++)
            wr(i[3:0], 8'h00);
        wr(4'hc, nf);
        wr(4'hb, 8'h07);
        irq_cnt = 0;
        wr(4'h1, c1 | 8'h80);
    endtask
    task automatic toggle(input int n, input int gap);
        repeat (n) begin
            @(posedge mclk);
            lvl <= ~lvl;
            repeat (gap - 1) @(posedge mclk);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        $display("mismatch at %0t: watchdog expired", $time);
        finish_test;
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        lvl = 1'b0;
        irq_cnt = 0;
        bad_count = 0;
        checked = 0;
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            rd(i[3:0], b);
            cmp({8'h00, b}, {8'h00, rst_tab[i]});
        end
        wr(4'hd, 8'h5a);
        rd(4'hd, b);
        cmp({8'h00, b}, 16'h0000);
        // Single edge polarity, ignored fields set, cascade chattering
        for (int k = 0; k < 2; k++) begin
            setup(8'h9e, k ? 8'h04 : 8'h44, 8'h00, 8'h00, 16'hffff);
            toggle(1, 20);
            grab;
            cmp(r | f | 16'(irq_cnt), 16'h0000);
            toggle(4, 40);
            grab;
            cmp(16'(irq_cnt), 16'h0002);
            cmp(k ? r : f, 16'h0000);
            cmp({8'h00, b}, k ? 16'h0002 : 16'h0001);
        end
        // Both edges: spacing, prescale, slow clock, reload wrap
        for (int k = 0; k < 4; k++) begin
            setup(tc0[k], tc1[k], tc2[k], 8'h00, trl[k]);
            toggle(3, tgap[k]);
            grab;
            cmp(lvl ? r - f : f - r, tdf[k]);
            cmp({8'h00, b}, tst[k]);
            cmp(16'(irq_cnt), 16'h0002);
        end
        // Interrupt source selection over ten reload periods
        for (int k = 0; k < 4; k++) begin
            setup(8'h80 | 8'(k << 5), 8'h04, 8'h10, 8'h00, 16'h0010);
            toggle(1, 8);
            #1 irq_cnt = 0;
            repeat (160) @(posedge mclk);
            #1 cmp(16'(irq_cnt), (k == 2) ? 16'h0000 : 16'h000a);
        end
        // Filtered input rejects a short glitch
        setup(8'h80, 8'h44, 8'h00, 8'hc0, 16'hffff);
        toggle(1, 600);
        toggle(2, 3);
        repeat (600) @(posedge mclk);
        cmp(16'(irq_cnt), 16'h0000);
        toggle(2, 600);
        cmp(16'(irq_cnt), 16'h0001);
        // Stopped timer holds count and flags until cleared
        wr(4'h1, 8'h44);
        rd16(4'h3, s);
        toggle(4, 20);
        rd16(4'h3, t);
        cmp(t, s);
        rd(4'hb, b);
        cmp({8'h00, b}, 16'h0001);
        wr(4'hb, 8'h07);
        rd(4'hb, b);
        cmp({8'h00, b}, 16'h0000);
        // Mode field other than demodulation
        for (int k = 0; k < 2; k++) begin
            setup(k ? 8'h80 : 8'h00, k ? 8'h40 : 8'h44, 8'h10, 8'h00, 16'hffff);
            toggle(4, 20);
            cmp(16'(irq_cnt), 16'h0000);
        end
        finish_test;
    end
endmodule
